// ### design/instrument_status_bits.sv
// Instrument condition status bank with change capture and summary bit
//
// The address map and the address-and-strobe port were chosen for this implementation.
module instrument_status_bits
  import status_bank_pkg::*;
#(
  parameter int VOLT_W = MV_W
)
(
  // Clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_reset,
  // Register port
  input  wire logic [ADDR_W-1:0]   i_address,
  input  wire logic [STATUS_W-1:0] i_write_data,
  input  wire logic                i_write_strobe,
  input  wire logic                i_read_strobe,
  output logic      [STATUS_W-1:0] o_read_data,
  // Instrument conditions
  input  wire conditions_t         i_conditions,
  input  wire logic [VOLT_W-1:0]   i_programmed_mv,
  input  wire logic                i_magnitude_change,
  input  wire logic                i_clear_status,
  // Status outputs
  output logic      [STATUS_W-1:0] o_status,
  output logic                     o_change_summary_bit
);

  localparam logic [VOLT_W-1:0] HV_LIMIT = VOLT_W'(HIGH_VOLTAGE_MV);

  bank_state_t         st_reg;
  bank_state_t         st_next;
  logic [STATUS_W-1:0] live;
  logic                high_voltage_flag;
  logic [STATUS_W-1:0] fall_set;
  logic [STATUS_W-1:0] rise_set;
  logic                fall_clear;
  logic                rise_clear;
  logic [STATUS_W-1:0] fall_cap;
  logic [STATUS_W-1:0] rise_cap;
  logic [STATUS_W-1:0] mag_bit;

  // Pack live conditions into their bit positions
  function automatic logic [STATUS_W-1:0] build_status(
    input conditions_t c,
    input logic        hv
  );
    logic [STATUS_W-1:0] s;
    s                   = STATUS_RESET;
    s[BIT_REPORT_BUSY]  = c.report_busy;
    s[BIT_OUTPUT_A]     = c.output_a;
    s[BIT_REMOTE]       = c.remote;
    s[BIT_HIGH_VOLTAGE] = hv;
    s[BIT_MAGNITUDE]    = 1'b0;
    s[BIT_TEMP_CAL]     = c.temporary_calibration_flag;
    s[BIT_OPERATE]      = c.operate_state;
    return s & ASSIGNED_MASK;
  endfunction

  // Read decode used by the capture clears; the read data path decodes with its own case
  function automatic logic is_read(
    input logic              strobe,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] target
  );
    return strobe && (addr == target);
  endfunction

  // Strictly above the limit; exactly 33 V stays low
  assign high_voltage_flag = (i_programmed_mv > HV_LIMIT);
  assign live              = build_status(i_conditions, high_voltage_flag);

  // Magnitude change lands only in the capture registers
  assign mag_bit = (st_reg.primed && i_magnitude_change) ? (16'h0001 << BIT_MAGNITUDE) : 16'h0000;

  // Edges against last cycle; none before the first sample after reset
  assign fall_set = (st_reg.primed ? (st_reg.status & ~live) : 16'h0000) | mag_bit;
  assign rise_set = (st_reg.primed ? (~st_reg.status & live) : 16'h0000) | mag_bit;

  // Reading a capture register or clear-status empties it
  assign fall_clear = i_clear_status || is_read(i_read_strobe, i_address, ADDR_FALL_CAP);
  assign rise_clear = i_clear_status || is_read(i_read_strobe, i_address, ADDR_RISE_CAP);

  // Capture of one-to-zero transitions
  change_capture u_fall_capture (
    .i_clock   (i_clock),
    .i_reset   (i_reset),
    .i_set     (fall_set),
    .i_clear   (fall_clear),
    .o_capture (fall_cap)
  );

  // Capture of zero-to-one transitions
  change_capture u_rise_capture (
    .i_clock   (i_clock),
    .i_reset   (i_reset),
    .i_set     (rise_set),
    .i_clear   (rise_clear),
    .o_capture (rise_cap)
  );

  // Next state: status sample, enable writes, read data, summary
  always_comb begin
    st_next        = st_reg;
    st_next.primed = 1'b1;
    st_next.status = live;
    st_next.rdata  = 16'h0000;
    // Masks keep only assigned positions
    if (i_write_strobe) begin
      case (i_address)
        ADDR_FALL_EN: begin
          st_next.en_fall = i_write_data & ASSIGNED_MASK;
        end
        ADDR_RISE_EN: begin
          st_next.en_rise = i_write_data & ASSIGNED_MASK;
        end
        default: begin
          st_next.en_fall = st_reg.en_fall;
        end
      endcase
    end
    // Read data stands for one cycle only
    if (i_read_strobe) begin
      case (i_address)
        ADDR_STATUS: begin
          st_next.rdata = st_reg.status;
        end
        ADDR_FALL_CAP: begin
          st_next.rdata = fall_cap;
        end
        ADDR_RISE_CAP: begin
          st_next.rdata = rise_cap;
        end
        ADDR_FALL_EN: begin
          st_next.rdata = st_reg.en_fall;
        end
        ADDR_RISE_EN: begin
          st_next.rdata = st_reg.en_rise;
        end
        default: begin
          st_next.rdata = 16'h0000;
        end
      endcase
    end
    // Summary follows captured bits that are enabled; zero masks keep it low
    st_next.summary = |((fall_cap & st_reg.en_fall) | (rise_cap & st_reg.en_rise));
  end

  // State register
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      st_reg.primed  <= 1'b0;
      st_reg.status  <= STATUS_RESET;
      st_reg.en_fall <= ENABLE_RESET;
      st_reg.en_rise <= ENABLE_RESET;
      st_reg.rdata   <= 16'h0000;
      st_reg.summary <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_read_data          = st_reg.rdata;
  assign o_status             = st_reg.status;
  assign o_change_summary_bit = st_reg.summary;

  // Report-busy mirrors the report activity one cycle later
  a_report_busy_bit: assert property (@(posedge i_clock) disable iff (i_reset)
    ##1 (o_status[BIT_REPORT_BUSY] == $past(i_conditions.report_busy)))
    else $error("report busy bit wrong");

  // Output_a bit rises one cycle after the output condition rises
  a_output_a_bit: assert property (@(posedge i_clock) disable iff (i_reset)
    $rose(i_conditions.output_a) |=> o_status[BIT_OUTPUT_A])
    else $error("output_a bit did not rise");

  // Remote bit tracks the control mode
  a_remote_bit: assert property (@(posedge i_clock) disable iff (i_reset)
    i_conditions.remote != o_status[BIT_REMOTE] |=> o_status[BIT_REMOTE] == $past(i_conditions.remote))
    else $error("remote bit wrong");

  // High-voltage bit against the 33 V threshold
  a_high_voltage_bit: assert property (@(posedge i_clock) disable iff (i_reset)
    ##1 (o_status[BIT_HIGH_VOLTAGE] == ($past(i_programmed_mv) > HV_LIMIT)))
    else $error("high voltage bit wrong");

  // Magnitude position never set in status or its read back
  a_magnitude_zero: assert property (@(posedge i_clock) disable iff (i_reset)
    !o_status[BIT_MAGNITUDE] && !($past(i_read_strobe && i_address == ADDR_STATUS) && o_read_data[BIT_MAGNITUDE]))
    else $error("magnitude bit seen in status");

  // Magnitude change shows in both capture registers
  a_magnitude_capture: assert property (@(posedge i_clock) disable iff (i_reset)
    (st_reg.primed && i_magnitude_change) |=> (fall_cap[BIT_MAGNITUDE] && rise_cap[BIT_MAGNITUDE]))
    else $error("magnitude change not captured");

  // Temporary calibration bit
  a_temp_cal_bit: assert property (@(posedge i_clock) disable iff (i_reset)
    ##1 (o_status[BIT_TEMP_CAL] == $past(i_conditions.temporary_calibration_flag)))
    else $error("temporary calibration bit wrong");

  // Operate bit
  a_operate_bit: assert property (@(posedge i_clock) disable iff (i_reset)
    ##1 (o_status[BIT_OPERATE] == $past(i_conditions.operate_state)))
    else $error("operate bit wrong");

  // Read of the rising capture register returns it and clears it
  a_read_clears: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_read_strobe && i_address == ADDR_RISE_CAP && rise_set == 16'h0000)
      |=> (o_read_data == $past(rise_cap)) && (rise_cap == 16'h0000))
    else $error("rising capture read did not clear");

  // Clear-status empties both captures
  a_clear_status: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_clear_status && fall_set == 16'h0000 && rise_set == 16'h0000)
      |=> (fall_cap == 16'h0000) && (rise_cap == 16'h0000))
    else $error("clear status left captures");

  // All masks zero keeps summary low
  a_summary_quiet: assert property (@(posedge i_clock) disable iff (i_reset)
    (st_reg.en_fall == 16'h0000 && st_reg.en_rise == 16'h0000) |=> !o_change_summary_bit)
    else $error("summary set with masks clear");

  // Enabled falling capture raises summary next cycle
  a_summary_sets: assert property (@(posedge i_clock) disable iff (i_reset)
    ((fall_cap & st_reg.en_fall) != 16'h0000) |=> o_change_summary_bit)
    else $error("summary missed enabled change");

  // Falling edge of a status bit lands in the first capture register
  a_fall_edge: assert property (@(posedge i_clock) disable iff (i_reset)
    (st_reg.primed && st_reg.status[BIT_REMOTE] && !live[BIT_REMOTE]) |=> fall_cap[BIT_REMOTE])
    else $error("falling edge not captured");

  // Rising edge lands in the second
  a_rise_edge: assert property (@(posedge i_clock) disable iff (i_reset)
    (st_reg.primed && !st_reg.status[BIT_OPERATE] && live[BIT_OPERATE]) |=> rise_cap[BIT_OPERATE])
    else $error("rising edge not captured");

  // Unassigned positions stay zero everywhere
  a_unassigned_zero: assert property (@(posedge i_clock) disable iff (i_reset)
    ((o_status | o_read_data | fall_cap | rise_cap | st_reg.en_fall | st_reg.en_rise) & ~ASSIGNED_MASK) == 16'h0000)
    else $error("unassigned bit set");

  // Main scenarios
  c_summary_raised: cover property (@(posedge i_clock) disable iff (i_reset) $rose(o_change_summary_bit));
  c_read_falling: cover property (@(posedge i_clock) disable iff (i_reset)
    i_read_strobe && i_address == ADDR_FALL_CAP && fall_cap != 16'h0000);
  c_set_and_clear: cover property (@(posedge i_clock) disable iff (i_reset)
    i_clear_status && rise_set != 16'h0000);

endmodule

// ### design/status_bank_pkg.sv
// Package of constants and types for the instrument condition status bank
// Behaviour
// - Report-busy bit is 1 exactly while a calibration report is sent.
// - Output_a bit is 1 once output is within tolerance, 0 while settling.
// - Remote bit is 1 under remote control, 0 under local control.
// - High-voltage bit is 1 when programmed voltage exceeds 33 V.
// - Magnitude-change position always reads 0 in the status register.
// - Magnitude-change bit is set only in both change-capture registers.
// - Temporary-calibration bit is 1 while unstored calibration constants are used.
// - High voltage at 7, magnitude at 6, temp cal at 5, operate at 0.
// - Operate bit is 1 in operate, 0 in standby.
// - Capture registers clear at power-on, on their own read, on clear-status.
// - Summary bit set by enabled captured change; never while masks are all 0.
// - Falling edges go to first capture register, rising edges to second.
package status_bank_pkg;

  // Register bus geometry
  localparam int STATUS_W = 16;
  localparam int ADDR_W   = 3;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_FALL_CAP = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_RISE_CAP = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_FALL_EN  = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_RISE_EN  = 3'h4;

  // Bit positions inside every register of the bank
  localparam int BIT_REPORT_BUSY  = 12;
  localparam int BIT_OUTPUT_A     = 11;
  localparam int BIT_REMOTE       = 10;
  localparam int BIT_HIGH_VOLTAGE = 7;
  localparam int BIT_MAGNITUDE    = 6;
  localparam int BIT_TEMP_CAL     = 5;
  localparam int BIT_OPERATE      = 0;

  // Positions that hold a real bit; all others read 0
  localparam logic [STATUS_W-1:0] ASSIGNED_MASK = 16'h1CE1;

  // Reset values
  localparam logic [STATUS_W-1:0] STATUS_RESET  = 16'h0000;
  localparam logic [STATUS_W-1:0] CAPTURE_RESET = 16'h0000;
  localparam logic [STATUS_W-1:0] ENABLE_RESET  = 16'h0000;

  // High-voltage threshold, programmed voltage given in millivolts
  localparam int MV_W               = 20;
  localparam int HIGH_VOLTAGE_VOLTS = 33;
  localparam int MV_PER_VOLT        = 1000;
  localparam int HIGH_VOLTAGE_MV    = HIGH_VOLTAGE_VOLTS * MV_PER_VOLT;

  // Live instrument conditions from the rest of the instrument
  typedef struct packed {
    logic report_busy;
    logic output_a;
    logic remote;
    logic temporary_calibration_flag;
    logic operate_state;
  } conditions_t;

  // State of one change-capture register
  typedef struct packed {
    logic [STATUS_W-1:0] bits;
  } capture_state_t;

  // State of the bank itself
  typedef struct packed {
    logic                primed;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] en_fall;
    logic [STATUS_W-1:0] en_rise;
    logic [STATUS_W-1:0] rdata;
    logic                summary;
  } bank_state_t;

endpackage

// ### design/change_capture.sv
// One sticky change-capture register with clear, set wins over clear
module change_capture
  import status_bank_pkg::*;
(
  // Clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_reset,
  // Events and clear
  input  wire logic [STATUS_W-1:0] i_set,
  input  wire logic                i_clear,
  // Captured bits
  output logic      [STATUS_W-1:0] o_capture
);

  capture_state_t cap_reg;
  capture_state_t cap_next;

  // A change in the clearing cycle must survive the clear
  always_comb begin
    cap_next      = cap_reg;
    cap_next.bits = ((i_clear ? CAPTURE_RESET : cap_reg.bits) | i_set) & ASSIGNED_MASK;
  end

  // State register
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      cap_reg.bits <= CAPTURE_RESET;
    end else begin
      cap_reg <= cap_next;
    end
  end

  assign o_capture = cap_reg.bits;

  // Set beats a simultaneous clear
  a_set_wins_clear: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_set != 16'h0000) |=> ((o_capture & $past(i_set)) == $past(i_set)))
    else $error("capture lost an event");

  // A clear with no new event empties the register
  a_clear_empties: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_clear && i_set == 16'h0000) |=> (o_capture == 16'h0000))
    else $error("capture not cleared");

endmodule

// ### verif/host_model.sv
// Behavioural remote host that drives the plain register port of the status bank
module host_model
  import status_bank_pkg::*;
(
  // Clock
  input  wire logic                i_clock,
  // Answer from the bank
  input  wire logic [STATUS_W-1:0] i_read_data,
  // Requests to the bank
  output logic      [ADDR_W-1:0]   o_address,
  output logic      [STATUS_W-1:0] o_write_data,
  output logic                     o_write_strobe,
  output logic                     o_read_strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet port at time zero
  initial begin
    o_address      = '0;
    o_write_data   = '0;
    o_write_strobe = 1'b0;
    o_read_strobe  = 1'b0;
  end

  // Idle lines show inverted values so stale data never looks valid
  task automatic release_bus(input logic [ADDR_W-1:0] a, input logic [STATUS_W-1:0] d);
    o_address    <= ~a;
    o_write_data <= ~d;
  endtask

  // One-cycle write, held until the sampling edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [STATUS_W-1:0] d);
    @(posedge i_clock);
    o_address      <= a;
    o_write_data   <= d;
    o_write_strobe <= 1'b1;
    @(posedge i_clock);
    o_write_strobe <= 1'b0;
    release_bus(a, d);
  endtask

  // One-cycle read; data stands only in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [STATUS_W-1:0] d);
    @(posedge i_clock);
    o_address     <= a;
    o_read_strobe <= 1'b1;
    @(posedge i_clock);
    o_read_strobe <= 1'b0;
    release_bus(a, o_write_data);
    // Sampled at the next edge: the word launched by the read edge, before it goes back to 0
    @(posedge i_clock);
    d = i_read_data;
  endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the instrument condition status bank
module tb_top
  import status_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                i_clock = 1'b0;
  logic                i_reset = 1'b1;
  logic [ADDR_W-1:0]   address;
  logic [STATUS_W-1:0] write_data;
  logic                write_strobe;
  logic                read_strobe;
  logic [STATUS_W-1:0] read_data;
  conditions_t         cond = '0;
  logic [MV_W-1:0]     prog_mv = '0;
  logic                mag_pulse = 1'b0;
  logic                clr_pulse = 1'b0;
  logic [STATUS_W-1:0] status;
  logic                summary;
  int                  n_fail = 0;
  int                  check_count = 0;
  // Status position of each condition bit, lsb of the struct first
  localparam int POS [5] = '{BIT_OPERATE, BIT_TEMP_CAL, BIT_REMOTE, BIT_OUTPUT_A, BIT_REPORT_BUSY};

  // 25 MHz clock
  always #20 i_clock = ~i_clock;

  instrument_status_bits instrument_status_bits_inst (
    .i_clock              (i_clock),
    .i_reset              (i_reset),
    .i_address            (address),
    .i_write_data         (write_data),
    .i_write_strobe       (write_strobe),
    .i_read_strobe        (read_strobe),
    .o_read_data          (read_data),
    .i_conditions         (cond),
    .i_programmed_mv      (prog_mv),
    .i_magnitude_change   (mag_pulse),
    .i_clear_status       (clr_pulse),
    .o_status             (status),
    .o_change_summary_bit (summary)
  );

  host_model host_model_inst (
    .i_clock        (i_clock),
    .i_read_data    (read_data),
    .o_address      (address),
    .o_write_data   (write_data),
    .o_write_strobe (write_strobe),
    .o_read_strobe  (read_strobe)
  );

  task automatic chk(input string name, input logic [STATUS_W-1:0] exp, input logic [STATUS_W-1:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rdchk(input string name, input logic [ADDR_W-1:0] a, input logic [STATUS_W-1:0] exp);
    logic [STATUS_W-1:0] d;
    host_model_inst.rd(a, d);
    chk(name, exp, d);
  endtask

  // Live status lags inputs by one edge; three edges leave margin
  // Values read at an edge are those registered one edge earlier
  task automatic settle();
    repeat (3) @(posedge i_clock);
  endtask

  // Pulse lands in capture at the next edge, summary one edge later
  task automatic mag_change();
    @(posedge i_clock);
    mag_pulse <= 1'b1;
    @(posedge i_clock);
    mag_pulse <= 1'b0;
    repeat (2) @(posedge i_clock);
  endtask

  task automatic clear_status();
    @(posedge i_clock);
    clr_pulse <= 1'b1;
    @(posedge i_clock);
    clr_pulse <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    // Every index, unmapped ones too, reads zero after reset
    for (int a = 0; a < 8; a++) begin
      rdchk("reset read", ADDR_W'(a), 16'h0000);
    end
    $display("Test reset values done");

    // One condition at a time, each to its own position
    for (int i = 0; i < 5; i++) begin
      cond <= conditions_t'(5'h01 << i);
      settle();
      chk("status condition", 16'h0001 << POS[i], status);
    end
    host_model_inst.wr(ADDR_STATUS, 16'hFFFF);
    rdchk("status after write", ADDR_STATUS, 16'h1000);
    cond <= '0;
    prog_mv <= MV_W'(HIGH_VOLTAGE_MV);
    settle();
    chk("high voltage at limit", 16'h0000, status);
    prog_mv <= MV_W'(HIGH_VOLTAGE_MV + 1);
    settle();
    chk("high voltage above", 16'h0080, status);
    prog_mv <= '0;
    settle();
    chk("high voltage cleared", 16'h0000, status);
    $display("Test live status done");

    // Edge capture, read-to-clear and clear-status
    clear_status();
    rdchk("falling after clear", ADDR_FALL_CAP, 16'h0000);
    rdchk("rising after clear", ADDR_RISE_CAP, 16'h0000);
    cond.operate_state <= 1'b1;
    settle();
    rdchk("rising capture", ADDR_RISE_CAP, 16'h0001);
    rdchk("rising after read", ADDR_RISE_CAP, 16'h0000);
    rdchk("falling untouched", ADDR_FALL_CAP, 16'h0000);
    cond.operate_state <= 1'b0;
    settle();
    rdchk("falling capture", ADDR_FALL_CAP, 16'h0001);
    rdchk("rising no fall", ADDR_RISE_CAP, 16'h0000);
    $display("Test change capture done");

    // Magnitude change and summary with masks off, then with the rising mask on
    mag_change();
    chk("summary masks off", 16'h0000, {15'h0000, summary});
    chk("status magnitude", 16'h0000, status);
    rdchk("rising magnitude", ADDR_RISE_CAP, 16'h0040);
    rdchk("falling magnitude", ADDR_FALL_CAP, 16'h0040);
    host_model_inst.wr(ADDR_RISE_EN, 16'hFFFF);
    rdchk("rising enable", ADDR_RISE_EN, ASSIGNED_MASK);
    host_model_inst.wr(ADDR_RISE_CAP, 16'hFFFF);
    rdchk("capture write ignored", ADDR_RISE_CAP, 16'h0000);
    mag_change();
    chk("summary set", 16'h0001, {15'h0000, summary});
    rdchk("rising before clear", ADDR_RISE_CAP, 16'h0040);
    settle();
    chk("summary after read", 16'h0000, {15'h0000, summary});
    mag_change();
    clear_status();
    settle();
    chk("summary after clear", 16'h0000, {15'h0000, summary});
    rdchk("enable kept", ADDR_RISE_EN, ASSIGNED_MASK);
    rdchk("falling cleared", ADDR_FALL_CAP, 16'h0000);
    $display("Test magnitude and summary done");

    // Falling mask alone: a rise stays quiet, a fall raises the summary
    host_model_inst.wr(ADDR_RISE_EN, 16'h0000);
    host_model_inst.wr(ADDR_FALL_EN, 16'hFFFF);
    rdchk("falling enable", ADDR_FALL_EN, ASSIGNED_MASK);
    cond.remote <= 1'b1;
    settle();
    chk("summary rise masked", 16'h0000, {15'h0000, summary});
    rdchk("rising remote", ADDR_RISE_CAP, 16'h0400);
    cond.remote <= 1'b0;
    settle();
    chk("summary on fall", 16'h0001, {15'h0000, summary});
    rdchk("falling remote", ADDR_FALL_CAP, 16'h0400);
    $display("Test falling mask done");

    // Reset in mid-run empties captures, masks and summary; conditions stay quiet
    mag_change();
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    chk("summary after reset", 16'h0000, {15'h0000, summary});
    rdchk("falling after reset", ADDR_FALL_CAP, 16'h0000);
    rdchk("enable after reset", ADDR_FALL_EN, 16'h0000);
    rdchk("rising after reset", ADDR_RISE_CAP, 16'h0000);
    $display("Test mid-run reset done");
    tally_and_finish();
  end
endmodule
